// >>> design/smc_pkg.sv
// Constants shared by the SRAM memory controller
package smc_pkg;

	// Clock period and device timing, picoseconds
	localparam int CLK_PERIOD_PS = 5000;   // 200 MHz reference clock
	localparam int READ_TIME_PS  = 20000;  // Access time from select to data
	localparam int WRITE_TIME_PS = 13800;  // Least write strobe width
	localparam int TURN_TIME_PS  = 5000;   // Bus release after output disable

	// Least times round up to whole cycles
	localparam int READ_CYC  = (READ_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WRITE_CYC = (WRITE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TURN_CYC  = (TURN_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Pin synchroniser latency: three stages plus agreement register
	localparam int SYNC_LAT_CYC = 4;

	// Cycles that read select is held, including capture margin
	localparam int READ_HOLD_CYC = READ_CYC + SYNC_LAT_CYC + 1;

	// Pin widths
	localparam int ADDR_W = 19;  // Word address
	localparam int DATA_W = 32;  // Data bus

	// Pin levels after reset (deselected, strobes inactive)
	localparam logic RST_CS_N = 1'h1;
	localparam logic RST_CS_HI = 1'h0;
	localparam logic RST_WE_N = 1'h1;
	localparam logic RST_OE_N = 1'h1;

	// Counter width
	localparam int CNT_W = 4;

	// Controller states
	typedef enum logic [1:0] {
		SMC_IDLE = 2'h0,
		SMC_RD   = 2'h1,
		SMC_WR   = 2'h2,
		SMC_TURN = 2'h3
	} smc_state_t;

endpackage

// >>> design/smc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module smc_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] s1;       // First stage, read only by s2
	logic [W-1:0] s2;       // Second stage
	logic [W-1:0] s3;       // Third stage
	logic [W-1:0] next_out; // Filtered next value

	////////////////////////////////////////////////////////////////
	// Accept a change once stages two and three agree
	always_comb begin
		next_out = sync_out;
		if (s2 == s3) begin
			next_out = s2;
		end
	end

	// Stage registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1       <= '0;
			s2       <= '0;
			s3       <= '0;
			sync_out <= '0;
		end else begin
			s1       <= pin;
			s2       <= s1;
			s3       <= s2;
			sync_out <= next_out;
		end
	end

endmodule

// >>> design/smc_ctrl.sv
// External controller driving an asynchronous error-correcting SRAM
//
// Operation
// - Four controls, 19-bit address, 32-bit data
// - Read: selected, strobe high, output enable low
// - Write strobe low means write, bus input
// - Selected, both high: tri-state or function select
`timescale 1ns/1ps
module smc_ctrl
	import smc_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// User side
	input  wire logic              scrub_enable,
	input  wire logic              req_valid,
	input  wire logic              req_write,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	output logic                   req_ready,
	output logic                   rsp_valid,
	output logic      [DATA_W-1:0] rsp_rdata,
	output logic                   rsp_error,
	// Memory pins
	output logic                   chip_select_n,
	output logic                   chip_select_hi,
	output logic                   write_strobe_n,
	output logic                   output_enable_n,
	output logic      [ADDR_W-1:0] mem_addr,
	output logic      [DATA_W-1:0] dq_out,
	output logic                   dq_oe,
	input  wire logic [DATA_W-1:0] dq_in,
	input  wire logic              bit_error_flag
);

	smc_state_t        state;           // Current state
	smc_state_t        next_state;      // Next state
	logic [CNT_W-1:0]  cnt;             // Cycles left in phase
	logic [CNT_W-1:0]  next_cnt;        // Next count
	logic              next_cs_n;       // Next chip select low-active
	logic              next_cs_hi;      // Next chip select high-active
	logic              next_we_n;       // Next write strobe
	logic              next_oe_n;       // Next output enable
	logic              next_dq_oe;      // Next bus drive
	logic [ADDR_W-1:0] next_addr;       // Next address
	logic [DATA_W-1:0] next_dq_out;     // Next write data
	logic              next_ready;      // Next request ready
	logic              next_rsp_valid;  // Next response pulse
	logic [DATA_W-1:0] next_rdata;      // Next read data
	logic              next_rsp_error;  // Next error status
	logic [DATA_W-1:0] dq_sync;         // Synchronised data bus
	logic              err_sync;        // Synchronised error flag

	////////////////////////////////////////////////////////////////
	// Pin input synchronisers
	smc_sync #(.W(DATA_W)) u_dq_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.pin      (dq_in),
		.sync_out (dq_sync)
	);

	smc_sync #(.W(1)) u_err_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.pin      (bit_error_flag),
		.sync_out (err_sync)
	);

	////////////////////////////////////////////////////////////////
	// Sequencer next values
	always_comb begin
		next_state     = state;
		next_cnt       = cnt;
		next_cs_n      = chip_select_n;
		next_cs_hi     = chip_select_hi;
		next_we_n      = write_strobe_n;
		next_oe_n      = output_enable_n;
		next_dq_oe     = dq_oe;
		next_addr      = mem_addr;
		next_dq_out    = dq_out;
		next_rsp_valid = 1'h0;
		next_rdata     = rsp_rdata;
		next_rsp_error = rsp_error;
		case (state)
			SMC_IDLE: begin
				// Standby choice, output enable kept high
				next_cs_n  = ~scrub_enable;
				next_cs_hi = 1'h0;
				next_we_n  = 1'h1;
				next_oe_n  = 1'h1;
				next_dq_oe = 1'h0;
				if (req_valid) begin
					next_addr = req_addr;
					next_cs_n  = 1'h0;
					next_cs_hi = 1'h1;
					if (req_write) begin
						// Strobe low selects write, bus driven
						next_we_n   = 1'h0;
						next_dq_oe  = 1'h1;
						next_dq_out = req_wdata;
						next_cnt    = CNT_W'(WRITE_CYC - 1);
						next_state  = SMC_WR;
					end else begin
						// Strobe high, output enable low
						next_oe_n  = 1'h0;
						next_cnt   = CNT_W'(READ_HOLD_CYC - 1);
						next_state = SMC_RD;
					end
				end
			end
			SMC_RD: begin
				if (cnt == '0) begin
					// Deselect and disable together, never selected idle
					next_cs_n      = 1'h1;
					next_cs_hi     = 1'h0;
					next_oe_n      = 1'h1;
					next_rdata     = dq_sync;
					next_rsp_error = err_sync;
					next_rsp_valid = 1'h1;
					next_cnt       = CNT_W'(TURN_CYC - 1);
					next_state     = SMC_TURN;
				end else begin
					next_cnt = cnt - CNT_W'(1);
				end
			end
			SMC_WR: begin
				if (cnt == '0) begin
					// End write by deselect; data held one more cycle
					next_cs_n  = 1'h1;
					next_cs_hi = 1'h0;
					next_we_n  = 1'h1;
					next_cnt   = CNT_W'(TURN_CYC - 1);
					next_state = SMC_TURN;
				end else begin
					next_cnt = cnt - CNT_W'(1);
				end
			end
			SMC_TURN: begin
				// Bus released before next access
				next_dq_oe = 1'h0;
				if (cnt == '0) begin
					next_state = SMC_IDLE;
				end else begin
					next_cnt = cnt - CNT_W'(1);
				end
			end
			default: begin
				next_state = SMC_IDLE;
			end
		endcase
		next_ready = (next_state == SMC_IDLE);
	end

	// Sequencer registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state           <= SMC_IDLE;
			cnt             <= '0;
			chip_select_n   <= RST_CS_N;
			chip_select_hi  <= RST_CS_HI;
			write_strobe_n  <= RST_WE_N;
			output_enable_n <= RST_OE_N;
			dq_oe           <= 1'h0;
			mem_addr        <= '0;
			dq_out          <= '0;
			req_ready       <= 1'h0;
			rsp_valid       <= 1'h0;
			rsp_rdata       <= '0;
			rsp_error       <= 1'h0;
		end else begin
			state           <= next_state;
			cnt             <= next_cnt;
			chip_select_n   <= next_cs_n;
			chip_select_hi  <= next_cs_hi;
			write_strobe_n  <= next_we_n;
			output_enable_n <= next_oe_n;
			dq_oe           <= next_dq_oe;
			mem_addr        <= next_addr;
			dq_out          <= next_dq_out;
			req_ready       <= next_ready;
			rsp_valid       <= next_rsp_valid;
			rsp_rdata       <= next_rdata;
			rsp_error       <= next_rsp_error;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	logic [CNT_W-1:0] oe_low_cnt;       // Consecutive output enable low cycles
	logic [CNT_W-1:0] next_oe_low_cnt;  // Next low-cycle count

	// Count output enable low cycles, cleared once it is high
	always_comb begin
		next_oe_low_cnt = '0;
		if (!output_enable_n) begin
			next_oe_low_cnt = oe_low_cnt + CNT_W'(1);
		end
	end

	// Low-cycle counter register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_low_cnt <= '0;
		end else begin
			oe_low_cnt <= next_oe_low_cnt;
		end
	end

	logic selected;  // Device in active mode
	assign selected = !chip_select_n && chip_select_hi;

	sequence seq_write_pulse;
		!write_strobe_n [*3] ##1 write_strobe_n;
	endsequence

	sequence seq_read_end;
		output_enable_n && rsp_valid;
	endsequence

	read_pins_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!output_enable_n |-> (selected && write_strobe_n && !dq_oe))
		else $error("read pins wrong");
	write_bus_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!write_strobe_n |-> (selected && dq_oe && output_enable_n))
		else $error("write pins wrong");
	no_fsel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		selected |-> !(output_enable_n && write_strobe_n))
		else $error("selected with both strobes high");
	write_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(write_strobe_n) |-> seq_write_pulse)
		else $error("write strobe width wrong");
	read_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(output_enable_n) |-> (oe_low_cnt == CNT_W'(READ_HOLD_CYC)) and seq_read_end)
		else $error("read hold length wrong");
	read_turn_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(output_enable_n) |-> !dq_oe [*2])
		else $error("bus driven too soon after read");
	addr_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(selected && $past(selected)) |-> $stable(mem_addr))
		else $error("address moved during access");
	standby_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(req_ready && !$past(rsp_valid) && $past(req_ready) && $past(scrub_enable))
			|-> (!chip_select_n && !chip_select_hi && output_enable_n))
		else $error("scrub standby pins wrong");
	rsp_err_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rsp_valid |-> (rsp_error == $past(err_sync)))
		else $error("error status not captured");

endmodule

// >>> dv/smc_sram_model.sv
// Pin-level model of the error-correcting SRAM
`timescale 1ns/1ps
module smc_sram_model
	import smc_pkg::*;
(
	input  wire logic              chip_select_n,
	input  wire logic              chip_select_hi,
	input  wire logic              write_strobe_n,
	input  wire logic              output_enable_n,
	input  wire logic [ADDR_W-1:0] mem_addr,
	input  wire logic [DATA_W-1:0] dq_out,
	input  wire logic              dq_oe,
	output logic      [DATA_W-1:0] dq_in,
	output logic                   bit_error_flag
);
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]]; // Stored words
	logic              sel;                      // Device selected
	logic              rd;                       // Word read mode
	logic              rd_late;                  // Access time met
	logic [DATA_W-1:0] word;                     // Addressed word
	////////////////////////////////////////////////////////////////////////
	// Mode decode; either select inactive means standby
	assign sel = !chip_select_n && chip_select_hi;
	assign rd = sel && write_strobe_n && !output_enable_n;
	assign #20 rd_late = rd;
	// Array write on any change of the write pins; a low strobe writes whatever the output enable
	always @(chip_select_n or chip_select_hi or write_strobe_n or mem_addr or dq_out or dq_oe) begin
		if (!chip_select_n && chip_select_hi && !write_strobe_n && dq_oe) begin
			mem[mem_addr] = dq_out;
		end
	end
	// Bus level: no stale data before access time or when released
	always @(rd_late or dq_oe or dq_out or mem_addr) begin
		word = mem.exists(mem_addr) ? mem[mem_addr] : 32'hA5A5A5A5;
		if (rd_late) begin
			dq_in = word;
		end else if (dq_oe) begin
			dq_in = dq_out;
		end else begin
			dq_in = ~word;
		end
	end
	// Flag high on a failing read; driven low otherwise
	assign bit_error_flag = rd_late && (mem_addr[3:0] == 4'hF);
endmodule

// >>> dv/smc_ctrl_tb.sv
// Self-checking bench for the SRAM controller
`timescale 1ns/1ps
module smc_ctrl_tb
	import smc_pkg::*;
;
	logic              ref_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              scrub_enable = 1'b0;
	logic              req_valid = 1'b0;
	logic              req_write = 1'b0;
	logic [ADDR_W-1:0] req_addr = '0;
	logic [DATA_W-1:0] req_wdata = '0;
	logic              req_ready, rsp_valid, rsp_error;
	logic [DATA_W-1:0] rsp_rdata, dq_out, dq_in;
	logic              chip_select_n, chip_select_hi, write_strobe_n, output_enable_n, dq_oe, bit_error_flag;
	logic [ADDR_W-1:0] mem_addr;
	logic [DATA_W-1:0] exp_mem [logic [ADDR_W-1:0]]; // Expected contents
	logic [ADDR_W-1:0] q [$];                        // Written addresses
	int                fail_count = 0;
	int                total_checks = 0;
	int                seed, i;
	logic [ADDR_W-1:0] a;
	always #2.5 ref_clk = ~ref_clk;
	smc_ctrl u_smc_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .scrub_enable(scrub_enable), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .chip_select_n(chip_select_n),
		.chip_select_hi(chip_select_hi), .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
		.mem_addr(mem_addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .bit_error_flag(bit_error_flag));
	smc_sram_model u_smc_sram_model (.chip_select_n(chip_select_n), .chip_select_hi(chip_select_hi),
		.write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n), .mem_addr(mem_addr),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .bit_error_flag(bit_error_flag));
	////////////////////////////////////////////////////////////////////////
	// Expected error flag for an address
	function automatic logic exp_err(input logic [ADDR_W-1:0] ad);
		return ad[3:0] == 4'hF;
	endfunction
	// Compare and count
	task automatic chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One request, a refused one during its busy time, then idle pins
	task automatic do_op(input logic wr, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
		int k, hit, n, done;
		for (k = 0; k < 30 && req_ready !== 1'b1; k++) begin
			@(posedge ref_clk);
		end
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_write <= wr;
		req_addr <= ad;
		req_wdata <= d;
		scrub_enable <= 1'($random(seed));
		@(posedge ref_clk);
		req_valid <= 1'b0;
		#1;
		chk("sel_n", 0, chip_select_n);
		chk("sel_hi", 1, chip_select_hi);
		chk("strobe_n", !wr, write_strobe_n);
		chk("oe_n", wr, output_enable_n);
		chk("dq_oe", wr, dq_oe);
		chk("addr", ad, mem_addr);
		hit = 0;
		n = 0;
		done = 0;
		for (k = 1; k <= 14; k++) begin
			@(posedge ref_clk);
			req_valid <= (k == 2);
			req_write <= 1'b1;
			req_wdata <= ~d;
			#1;
			if (rsp_valid === 1'b1) begin
				hit = k;
				n++;
			end
			if (req_ready === 1'b1 && done == 0) begin
				done = k;
			end
		end
		chk("ready_back", wr ? WRITE_CYC + TURN_CYC : READ_HOLD_CYC + TURN_CYC, done);
		if (wr) begin
			exp_mem[ad] = d;
			q.push_back(ad);
		end else begin
			chk("rsp_at", READ_HOLD_CYC, hit);
			chk("rsp_count", 1, n);
			chk("rdata", exp_mem[ad], rsp_rdata);
			chk("rerr", exp_err(ad), rsp_error);
		end
		chk("idle_sel_n", !scrub_enable, chip_select_n);
		chk("idle_sel_hi", 0, chip_select_hi);
		chk("idle_dq_oe", 0, dq_oe);
	endtask
	// Verdict and end of run
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Corner addresses and data, then random writes alternating with reads of written addresses
	initial begin
		seed = 32'h3f2e1cd4;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		do_op(1'b1, 19'h00000, 32'h00000000);
		do_op(1'b1, 19'h7FFFF, 32'hFFFFFFFF);
		do_op(1'b0, 19'h7FFFF, 32'h00000000);
		do_op(1'b0, 19'h00000, 32'h00000000);
		for (i = 0; i < 40; i++) begin
			a = ADDR_W'($random(seed));
			if (i % 2 == 0) begin
				do_op(1'b1, a, $random(seed));
			end else begin
				do_op(1'b0, q[$unsigned($random(seed)) % q.size()], 32'h00000000);
			end
		end
		close_out;
	end
	// Watchdog
	initial begin
		#50000;
		fail_count++;
		close_out;
	end
endmodule
